// ---- sdd_pkg.sv ----
package sdd_pkg;

	////////////////////////////////////////////////////////////////////////
	// register addresses on the special function register port
	localparam logic [7:0] ADDR_CFG = 8'h95;
	localparam logic [7:0] ADDR_CLK = 8'h96;
	localparam logic [7:0] ADDR_SEGL = 8'h97;
	localparam logic [7:0] ADDR_CFGX = 8'h9c;
	localparam logic [7:0] ADDR_PTR = 8'hac;
	localparam logic [7:0] ADDR_DAT = 8'hae;
	localparam logic [7:0] ADDR_CFGY = 8'hb1;
	localparam logic [7:0] ADDR_SEGH = 8'hed;

	////////////////////////////////////////////////////////////////////////
	// field positions and reset values
	localparam int CFG_EN_BIT = 7;
	localparam int CFG_CLR_BIT = 6;
	localparam int CFG_BLINK_BIT = 5;
	localparam int CFG_SLEEP_BIT = 4;
	localparam int CFG_CKSEL_BIT = 3;
	localparam int CFG_BIAS_BIT = 2;
	localparam int CFG_MUX_HI = 1;
	localparam int CFG_MUX_LO = 0;
	localparam int CLK_BMOD_HI = 7;
	localparam int CLK_BMOD_LO = 6;
	localparam int CLK_BRATE_HI = 5;
	localparam int CLK_BRATE_LO = 4;
	localparam int CLK_FD_HI = 3;
	localparam int CLK_FD_LO = 0;
	localparam int CFGX_EXT_BIT = 6;
	localparam int CFGY_INV_BIT = 6;
	localparam int CFGY_UPD_BIT = 1;
	localparam int CFGY_HOLD_BIT = 0;
	localparam logic [7:0] CFGX_MASK = 8'h40;
	localparam logic [7:0] CFGY_MASK = 8'h41;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [3:0] NIB_ZERO = 4'h0;

	////////////////////////////////////////////////////////////////////////
	// multiplex and blink codes
	localparam logic [1:0] MUX_RSVD = 2'h0;
	localparam logic [1:0] MUX_2 = 2'h1;
	localparam logic [1:0] MUX_3 = 2'h2;
	localparam logic [1:0] MUX_4 = 2'h3;
	localparam logic [1:0] BMOD_SW_OFF = 2'h0;
	localparam logic [1:0] BMOD_SW_ON = 2'h1;
	localparam logic [1:0] BMOD_FIXED = 2'h2;
	localparam logic [1:0] BMOD_RATE = 2'h3;
	localparam logic [1:0] BRATE_1 = 2'h0;
	localparam logic [1:0] BRATE_2 = 2'h1;
	localparam logic [1:0] BRATE_3 = 2'h2;
	localparam logic [1:0] BRATE_4 = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// panel geometry; pins 0..14 are dedicated segment lines
	localparam int LOC_COUNT = 17;
	localparam int PIN_COUNT = 19;
	localparam int DED_SEG = 15;
	localparam int PIN_SHARED_FOUR = 15;
	localparam int PIN_SHARED_THREE = 16;
	localparam int PIN_COM0 = 17;
	localparam int PIN_COM1 = 18;
	localparam logic [7:0] LOC_LIMIT = 8'h11;
	localparam logic [1:0] COM_IDX0 = 2'h0;
	localparam logic [1:0] COM_IDX1 = 2'h1;
	localparam logic [1:0] COM_IDX2 = 2'h2;
	localparam logic [1:0] COM_IDX3 = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// ladder level codes driven toward the panel
	localparam logic [1:0] LVL_V0 = 2'h0;
	localparam logic [1:0] LVL_V1 = 2'h1;
	localparam logic [1:0] LVL_V2 = 2'h2;
	localparam logic [1:0] LVL_V3 = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// timing, in ticks of the 32768 Hz low-frequency strobe
	localparam int TICK_HZ = 32768;
	localparam int DRV_FAST_HZ = 2048;
	localparam int DRV_SLOW_HZ = 128;
	localparam int BLINK_FIXED_HZ = 2;
	localparam logic [7:0] DIV_FAST_M1 = 8'(TICK_HZ / DRV_FAST_HZ - 1);
	localparam logic [7:0] DIV_SLOW_M1 = 8'(TICK_HZ / DRV_SLOW_HZ - 1);
	// half periods: one toggle of the blink phase per half period
	localparam logic [15:0] BL_FIXED_M1 =
		16'(TICK_HZ / (2 * BLINK_FIXED_HZ) - 1);
	localparam logic [15:0] BL_1_M1 = 16'(TICK_HZ / 2 - 1);
	localparam logic [15:0] BL_2_M1 = 16'(2 * TICK_HZ / 2 - 1);
	localparam logic [15:0] BL_3_M1 = 16'(3 * TICK_HZ / 2 - 1);
	localparam logic [15:0] BL_4_M1 = 16'(4 * TICK_HZ / 2 - 1);

	typedef logic [LOC_COUNT-1:0][3:0] sdd_frame_t;

	// last scan phase equals the multiplex code (2, 3 or 4 backplanes)
	function automatic logic [1:0] sdd_last_phase(input logic [1:0] mux);
		return mux;
	endfunction

	// shared pin becomes a common line at or above the given level
	function automatic logic sdd_is_com(input logic [1:0] mux,
		input logic [1:0] lvl);
		return (mux >= lvl);
	endfunction

endpackage

// ---- sdd_scan_if.sv ----
`timescale 1ns/1ps
interface sdd_scan_if;
	logic [1:0] phase;
	logic pol;
	logic blank;
	logic bias_third;
	logic [1:0] mux;
	modport ctrl (output phase, output pol, output blank,
		output bias_third, output mux);
	modport scan (input phase, input pol, input blank,
		input bias_third, input mux);
endinterface

// ---- sdd_timebase.sv ----
`timescale 1ns/1ps
module sdd_timebase (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_tick,
	input wire logic i_run,
	input wire logic i_slow,
	input wire logic [3:0] i_fd,
	input wire logic [1:0] i_last,
	input wire logic i_inv_frame,
	input wire logic [1:0] i_blink_mode,
	input wire logic [1:0] i_blink_rate,
	output logic o_frame_start,
	output logic [1:0] o_phase,
	output logic o_pol,
	output logic o_blink_phase
);
	logic [7:0] div_r, div_nxt, div_lim;
	logic [3:0] fdc_r, fdc_nxt;
	logic [1:0] phase_r, phase_nxt;
	logic pol_r, pol_nxt, fs_r, fs_nxt, drv_w, step_w;
	logic [15:0] bcnt_r, bcnt_nxt, blim;
	logic blink_r, blink_nxt;

	////////////////////////////////////////////////////////////////////////
	// drive clock, phase and frame sequencing
	always_comb begin
		div_lim = i_slow ? sdd_pkg::DIV_SLOW_M1 : sdd_pkg::DIV_FAST_M1;
		div_nxt = div_r;
		fdc_nxt = fdc_r;
		phase_nxt = phase_r;
		pol_nxt = pol_r;
		fs_nxt = 1'b0;
		drv_w = 1'b0;
		step_w = 1'b0;
		if (!i_run) begin
			div_nxt = '0;
			fdc_nxt = '0;
			phase_nxt = '0;
			pol_nxt = 1'b0;
		end else if (i_tick) begin
			// >= so a switch to the fast clock never overruns
			if (div_r >= div_lim) begin
				div_nxt = '0;
				drv_w = 1'b1;
			end else begin
				div_nxt = div_r + 8'h01;
			end
		end
		if (drv_w) begin
			// each phase lasts frame divider plus one drive clocks
			if (fdc_r >= i_fd) begin
				fdc_nxt = '0;
				step_w = 1'b1;
			end else begin
				fdc_nxt = fdc_r + 4'h1;
			end
		end
		if (step_w) begin
			if (phase_r >= i_last) begin
				phase_nxt = '0;
				fs_nxt = 1'b1;
				if (i_inv_frame) begin
					pol_nxt = ~pol_r;
				end
			end else begin
				phase_nxt = phase_r + 2'h1;
			end
			if (!i_inv_frame) begin
				pol_nxt = ~pol_r;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			div_r <= '0;
			fdc_r <= '0;
			phase_r <= '0;
			pol_r <= 1'b0;
			fs_r <= 1'b0;
		end else begin
			div_r <= div_nxt;
			fdc_r <= fdc_nxt;
			phase_r <= phase_nxt;
			pol_r <= pol_nxt;
			fs_r <= fs_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// blink phase generator
	always_comb begin
		unique case (i_blink_rate)
			sdd_pkg::BRATE_1: blim = sdd_pkg::BL_1_M1;
			sdd_pkg::BRATE_2: blim = sdd_pkg::BL_2_M1;
			sdd_pkg::BRATE_3: blim = sdd_pkg::BL_3_M1;
			sdd_pkg::BRATE_4: blim = sdd_pkg::BL_4_M1;
		endcase
		if (i_blink_mode == sdd_pkg::BMOD_FIXED) begin
			blim = sdd_pkg::BL_FIXED_M1;
		end
		bcnt_nxt = bcnt_r;
		blink_nxt = blink_r;
		if (!i_run) begin
			bcnt_nxt = '0;
			blink_nxt = 1'b1;
		end else if (i_tick) begin
			if (bcnt_r >= blim) begin
				bcnt_nxt = '0;
				blink_nxt = ~blink_r;
			end else begin
				bcnt_nxt = bcnt_r + 16'h0001;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			bcnt_r <= '0;
			blink_r <= 1'b1;
		end else begin
			bcnt_r <= bcnt_nxt;
			blink_r <= blink_nxt;
		end
	end

	assign o_frame_start = fs_r;
	assign o_phase = phase_r;
	assign o_pol = pol_r;
	assign o_blink_phase = blink_r;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);

	sequence s_last_step;
		i_run && step_w && (phase_r >= i_last);
	endsequence

	chk_phase_wrap: assert property (s_last_step |=> o_frame_start &&
		(o_phase == sdd_pkg::COM_IDX0))
		else $error("scan did not wrap to phase zero");
	chk_pol_alt: assert property (i_run && step_w && !i_inv_frame |=>
		o_pol != $past(o_pol))
		else $error("polarity did not alternate");
endmodule

// ---- sdd_scanner.sv ----
`timescale 1ns/1ps
module sdd_scanner (
	input wire logic i_mclk,
	input wire logic i_resetn,
	sdd_scan_if.scan ifc,
	input wire sdd_pkg::sdd_frame_t i_frame,
	input wire logic [sdd_pkg::LOC_COUNT-1:0] i_seg_en,
	output logic [sdd_pkg::PIN_COUNT-1:0][1:0] o_pin_lvl,
	output logic [sdd_pkg::PIN_COUNT-1:0] o_pin_drv
);
	logic [sdd_pkg::PIN_COUNT-1:0][1:0] lvl_r, lvl_nxt;
	logic [sdd_pkg::PIN_COUNT-1:0] drv_r, drv_nxt;
	logic [sdd_pkg::DED_SEG-1:0][1:0] seg_lvl_w;
	logic com_three, com_four;

	// segment level against the active backplane
	function automatic logic [1:0] seg_level(input logic on, input logic pol,
		input logic third);
		if (on) begin
			return pol ? sdd_pkg::LVL_V3 : sdd_pkg::LVL_V0;
		end
		if (third) begin
			return pol ? sdd_pkg::LVL_V1 : sdd_pkg::LVL_V2;
		end
		return sdd_pkg::LVL_V1;
	endfunction

	// backplane level; half bias joins the two middle nodes
	function automatic logic [1:0] com_level(input logic sel, input logic pol,
		input logic third);
		if (sel) begin
			return pol ? sdd_pkg::LVL_V0 : sdd_pkg::LVL_V3;
		end
		if (third) begin
			return pol ? sdd_pkg::LVL_V2 : sdd_pkg::LVL_V1;
		end
		return sdd_pkg::LVL_V1;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// dedicated segment lines
	genvar gi;
	generate
		for (gi = 0; gi < sdd_pkg::DED_SEG; gi++) begin : g_seg
			assign seg_lvl_w[gi] = ifc.blank ? sdd_pkg::LVL_V0 :
				seg_level(i_frame[gi][ifc.phase], ifc.pol, ifc.bias_third);
		end
	endgenerate

	// shared pins and backplanes
	always_comb begin
		com_three = sdd_pkg::sdd_is_com(ifc.mux, sdd_pkg::MUX_3);
		com_four = sdd_pkg::sdd_is_com(ifc.mux, sdd_pkg::MUX_4);
		lvl_nxt = '0;
		drv_nxt = '0;
		for (int i = 0; i < sdd_pkg::DED_SEG; i++) begin
			lvl_nxt[i] = seg_lvl_w[i];
			drv_nxt[i] = i_seg_en[i];
		end
		lvl_nxt[sdd_pkg::PIN_SHARED_FOUR] = com_four ?
			com_level(ifc.phase == sdd_pkg::COM_IDX3, ifc.pol, ifc.bias_third) :
			seg_level(i_frame[sdd_pkg::PIN_SHARED_FOUR][ifc.phase], ifc.pol,
				ifc.bias_third);
		lvl_nxt[sdd_pkg::PIN_SHARED_THREE] = com_three ?
			com_level(ifc.phase == sdd_pkg::COM_IDX2, ifc.pol, ifc.bias_third) :
			seg_level(i_frame[sdd_pkg::PIN_SHARED_THREE][ifc.phase], ifc.pol,
				ifc.bias_third);
		lvl_nxt[sdd_pkg::PIN_COM0] = com_level(ifc.phase == sdd_pkg::COM_IDX0,
			ifc.pol, ifc.bias_third);
		lvl_nxt[sdd_pkg::PIN_COM1] = com_level(ifc.phase == sdd_pkg::COM_IDX1,
			ifc.pol, ifc.bias_third);
		drv_nxt[sdd_pkg::PIN_SHARED_FOUR] = com_four ||
			i_seg_en[sdd_pkg::PIN_SHARED_FOUR];
		drv_nxt[sdd_pkg::PIN_SHARED_THREE] = com_three ||
			i_seg_en[sdd_pkg::PIN_SHARED_THREE];
		drv_nxt[sdd_pkg::PIN_COM0] = 1'b1;
		drv_nxt[sdd_pkg::PIN_COM1] = 1'b1;
		if (ifc.blank) begin
			lvl_nxt = '0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			lvl_r <= '0;
			drv_r <= '0;
		end else begin
			lvl_r <= lvl_nxt;
			drv_r <= drv_nxt;
		end
	end

	assign o_pin_lvl = lvl_r;
	assign o_pin_drv = drv_r;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);

	chk_shared_role: assert property (ifc.mux == sdd_pkg::MUX_4 |=>
		o_pin_drv[sdd_pkg::PIN_SHARED_FOUR] &&
		o_pin_drv[sdd_pkg::PIN_SHARED_THREE])
		else $error("shared pins not backplanes at four");
	chk_com_select: assert property (!ifc.blank && !ifc.pol &&
		ifc.phase == sdd_pkg::COM_IDX0 |=>
		o_pin_lvl[sdd_pkg::PIN_COM0] == sdd_pkg::LVL_V3)
		else $error("selected backplane level wrong");
endmodule

// ---- sdd_top.sv ----
`timescale 1ns/1ps
module sdd_top (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic [7:0] i_sfr_addr,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	output logic [7:0] o_sfr_rdata,
	output logic o_sfr_hit,
	input wire logic i_tick_32k,
	input wire logic i_sleep_power_mode,
	output logic [sdd_pkg::PIN_COUNT-1:0][1:0] o_pin_lvl,
	output logic [sdd_pkg::PIN_COUNT-1:0] o_pin_drv,
	output logic o_ladder_join,
	output logic o_ext_ladder_en,
	output logic o_update_finished_flag
);
	logic [7:0] cfg_r, cfg_nxt, clkc_r, clkc_nxt;
	logic [7:0] segl_r, segl_nxt, segh_r, segh_nxt;
	logic [7:0] cfgx_r, cfgx_nxt, cfgy_r, cfgy_nxt, ptr_r, ptr_nxt;
	logic upd_r, upd_nxt, join_r, join_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic hit_r, hit_nxt;
	sdd_pkg::sdd_frame_t mem_r, mem_nxt, fb_r, fb_nxt;
	logic [4:0] ptr_idx;
	logic ptr_ok, cur_sel, run_w, visible_w, frame_start, blink_phase;
	logic [3:0] cur_dat;
	logic [1:0] mux_w, phase_w, bmode_w;
	logic pol_w;
	logic [sdd_pkg::LOC_COUNT-1:0] seg_en_w;

	sdd_scan_if scan_bus ();

	////////////////////////////////////////////////////////////////////////
	// decoded fields
	assign mux_w = cfg_r[sdd_pkg::CFG_MUX_HI:sdd_pkg::CFG_MUX_LO];
	assign bmode_w = clkc_r[sdd_pkg::CLK_BMOD_HI:sdd_pkg::CLK_BMOD_LO];
	assign ptr_idx = ptr_r[4:0];
	assign ptr_ok = (ptr_r < sdd_pkg::LOC_LIMIT);
	assign cur_dat = ptr_ok ? mem_r[ptr_idx] : sdd_pkg::NIB_ZERO;
	// both shared pins answer to the top bit of the high enable byte
	assign seg_en_w = {segh_r[7], segh_r, segl_r};
	assign cur_sel = (i_sfr_addr == sdd_pkg::ADDR_DAT);

	////////////////////////////////////////////////////////////////////////
	// configuration registers, written over the register port
	always_comb begin
		cfg_nxt = cfg_r;
		clkc_nxt = clkc_r;
		segl_nxt = segl_r;
		segh_nxt = segh_r;
		cfgx_nxt = cfgx_r;
		cfgy_nxt = cfgy_r;
		ptr_nxt = ptr_r;
		if (i_sfr_wr) begin
			case (i_sfr_addr)
				sdd_pkg::ADDR_CFG: cfg_nxt = i_sfr_wdata;
				sdd_pkg::ADDR_CLK: clkc_nxt = i_sfr_wdata;
				sdd_pkg::ADDR_SEGL: segl_nxt = i_sfr_wdata;
				sdd_pkg::ADDR_SEGH: segh_nxt = i_sfr_wdata;
				sdd_pkg::ADDR_CFGX: cfgx_nxt = i_sfr_wdata & sdd_pkg::CFGX_MASK;
				sdd_pkg::ADDR_CFGY: cfgy_nxt = i_sfr_wdata & sdd_pkg::CFGY_MASK;
				sdd_pkg::ADDR_PTR: ptr_nxt = i_sfr_wdata;
				default: ;
			endcase
		end
		// half bias ties the two middle ladder nodes together
		join_nxt = !cfg_nxt[sdd_pkg::CFG_BIAS_BIT];
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			cfg_r <= sdd_pkg::REG_RESET;
			clkc_r <= sdd_pkg::REG_RESET;
			segl_r <= sdd_pkg::REG_RESET;
			segh_r <= sdd_pkg::REG_RESET;
			cfgx_r <= sdd_pkg::REG_RESET;
			cfgy_r <= sdd_pkg::REG_RESET;
			ptr_r <= sdd_pkg::REG_RESET;
			join_r <= 1'b1;
		end else begin
			cfg_r <= cfg_nxt;
			clkc_r <= clkc_nxt;
			segl_r <= segl_nxt;
			segh_r <= segh_nxt;
			cfgx_r <= cfgx_nxt;
			cfgy_r <= cfgy_nxt;
			ptr_r <= ptr_nxt;
			join_r <= join_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// display data memory and the frame copy the scanner shows
	always_comb begin
		mem_nxt = mem_r;
		fb_nxt = fb_r;
		if (i_sfr_wr && cur_sel && ptr_ok) begin
			mem_nxt[ptr_idx] = i_sfr_wdata[3:0];
		end
		// clear dominates any write made while it is set
		if (cfg_r[sdd_pkg::CFG_CLR_BIT]) begin
			mem_nxt = '0;
		end
		if (frame_start && !cfgy_r[sdd_pkg::CFGY_HOLD_BIT]) begin
			fb_nxt = mem_r;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			mem_r <= '0;
			fb_r <= '0;
		end else begin
			mem_r <= mem_nxt;
			fb_r <= fb_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// update finished flag: hardware set beats a software clear
	always_comb begin
		upd_nxt = upd_r;
		if (i_sfr_wr && i_sfr_addr == sdd_pkg::ADDR_CFGY &&
			!i_sfr_wdata[sdd_pkg::CFGY_UPD_BIT]) begin
			upd_nxt = 1'b0;
		end
		if (frame_start && !cfgy_r[sdd_pkg::CFGY_HOLD_BIT]) begin
			upd_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			upd_r <= 1'b0;
		end else begin
			upd_r <= upd_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port; unmapped addresses read zero with the hit flag low
	always_comb begin
		rdata_nxt = rdata_r;
		hit_nxt = hit_r;
		if (i_sfr_rd) begin
			hit_nxt = 1'b1;
			case (i_sfr_addr)
				sdd_pkg::ADDR_CFG: rdata_nxt = cfg_r;
				sdd_pkg::ADDR_CLK: rdata_nxt = clkc_r;
				sdd_pkg::ADDR_SEGL: rdata_nxt = segl_r;
				sdd_pkg::ADDR_SEGH: rdata_nxt = segh_r;
				sdd_pkg::ADDR_CFGX: rdata_nxt = cfgx_r;
				sdd_pkg::ADDR_CFGY: begin
					rdata_nxt = cfgy_r;
					rdata_nxt[sdd_pkg::CFGY_UPD_BIT] = upd_r;
				end
				sdd_pkg::ADDR_PTR: rdata_nxt = ptr_r;
				sdd_pkg::ADDR_DAT: rdata_nxt = {sdd_pkg::NIB_ZERO, cur_dat};
				default: begin
					rdata_nxt = sdd_pkg::REG_RESET;
					hit_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			rdata_r <= sdd_pkg::REG_RESET;
			hit_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			hit_r <= hit_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// run and blank decisions; no power mode stops the driver on its own
	assign run_w = cfg_r[sdd_pkg::CFG_EN_BIT] &&
		!(i_sleep_power_mode && cfg_r[sdd_pkg::CFG_SLEEP_BIT]) &&
		(mux_w != sdd_pkg::MUX_RSVD);

	always_comb begin
		visible_w = 1'b1;
		if (cfg_r[sdd_pkg::CFG_BLINK_BIT]) begin
			unique case (bmode_w)
				sdd_pkg::BMOD_SW_OFF: visible_w = 1'b0;
				sdd_pkg::BMOD_SW_ON: visible_w = 1'b1;
				sdd_pkg::BMOD_FIXED: visible_w = blink_phase;
				sdd_pkg::BMOD_RATE: visible_w = blink_phase;
			endcase
		end
	end

	assign scan_bus.phase = phase_w;
	assign scan_bus.pol = pol_w;
	assign scan_bus.blank = !run_w || !visible_w;
	assign scan_bus.bias_third = cfg_r[sdd_pkg::CFG_BIAS_BIT];
	assign scan_bus.mux = mux_w;

	////////////////////////////////////////////////////////////////////////
	sdd_timebase u_timebase (
		.i_mclk(i_mclk),
		.i_resetn(i_resetn),
		.i_tick(i_tick_32k),
		.i_run(run_w),
		.i_slow(cfg_r[sdd_pkg::CFG_CKSEL_BIT]),
		.i_fd(clkc_r[sdd_pkg::CLK_FD_HI:sdd_pkg::CLK_FD_LO]),
		.i_last(sdd_pkg::sdd_last_phase(mux_w)),
		.i_inv_frame(cfgy_r[sdd_pkg::CFGY_INV_BIT]),
		.i_blink_mode(bmode_w),
		.i_blink_rate(clkc_r[sdd_pkg::CLK_BRATE_HI:sdd_pkg::CLK_BRATE_LO]),
		.o_frame_start(frame_start),
		.o_phase(phase_w),
		.o_pol(pol_w),
		.o_blink_phase(blink_phase)
	);

	sdd_scanner u_scanner (
		.i_mclk(i_mclk),
		.i_resetn(i_resetn),
		.ifc(scan_bus.scan),
		.i_frame(fb_r),
		.i_seg_en(seg_en_w),
		.o_pin_lvl(o_pin_lvl),
		.o_pin_drv(o_pin_drv)
	);

	assign o_sfr_rdata = rdata_r;
	assign o_sfr_hit = hit_r;
	assign o_ladder_join = join_r;
	assign o_ext_ladder_en = cfgx_r[sdd_pkg::CFGX_EXT_BIT];
	assign o_update_finished_flag = upd_r;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);

	sequence s_load_frame;
		frame_start && !cfgy_r[sdd_pkg::CFGY_HOLD_BIT];
	endsequence

	chk_off_blank: assert property (!cfg_r[sdd_pkg::CFG_EN_BIT] |=>
		o_pin_lvl == '0)
		else $error("pins not blank while disabled");
	chk_clear_hold: assert property (cfg_r[sdd_pkg::CFG_CLR_BIT] |=>
		mem_r == '0)
		else $error("data memory not held at zero");
	chk_sleep_off: assert property (i_sleep_power_mode &&
		cfg_r[sdd_pkg::CFG_SLEEP_BIT] |=> o_pin_lvl == '0)
		else $error("display not forced off in sleep");
	chk_hold_frame: assert property (frame_start &&
		cfgy_r[sdd_pkg::CFGY_HOLD_BIT] |=> fb_r == $past(fb_r))
		else $error("frame changed during refresh hold");
	chk_load_frame: assert property (s_load_frame |=>
		fb_r == $past(mem_r))
		else $error("frame not loaded at frame start");
	chk_update_flag: assert property (s_load_frame |=> upd_r ##1
		(upd_r || $past(i_sfr_wr)))
		else $error("update flag not set at new frame");
	chk_ptr_read: assert property (i_sfr_rd && cur_sel |=>
		o_sfr_rdata == {sdd_pkg::NIB_ZERO, $past(cur_dat)} && o_sfr_hit)
		else $error("data port read wrong location");
	chk_blink_off: assert property (cfg_r[sdd_pkg::CFG_BLINK_BIT] &&
		bmode_w == sdd_pkg::BMOD_SW_OFF |=> o_pin_lvl == '0)
		else $error("software blink off did not blank");
	chk_rsvd_mux: assert property (mux_w == sdd_pkg::MUX_RSVD |=>
		o_pin_lvl == '0)
		else $error("reserved multiplex code scanned");

	// register side effects, seen after the edge that takes them
	chk_join_bias: assert property (o_ladder_join ==
		!cfg_r[sdd_pkg::CFG_BIAS_BIT])
		else $error("ladder join does not follow bias");
	chk_seg_enable: assert property (1'b1 |=>
		o_pin_drv[sdd_pkg::DED_SEG-1:0] ==
		$past(seg_en_w[sdd_pkg::DED_SEG-1:0]))
		else $error("segment pin role not from enables");
	chk_flag_clear: assert property (i_sfr_wr &&
		i_sfr_addr == sdd_pkg::ADDR_CFGY &&
		!i_sfr_wdata[sdd_pkg::CFGY_UPD_BIT] && !frame_start |=> !upd_r)
		else $error("update flag not cleared by software");
	chk_rdata_stands: assert property (!i_sfr_rd |=>
		$stable(o_sfr_rdata) && $stable(o_sfr_hit))
		else $error("read data changed without a read");
endmodule

// ---- sdd_panel.sv ----
`timescale 1ns/1ps
// passive panel: lit while the driven COM0 pin or the COM1 pin sits off the ground level
module sdd_panel (
	input wire logic i_mclk,
	input wire logic [sdd_pkg::PIN_COUNT-1:0][1:0] i_pin_lvl,
	input wire logic [sdd_pkg::PIN_COUNT-1:0] i_pin_drv,
	output logic o_lit
);
	// sampled on the clock so edge-time settling never counts as lit
	always_ff @(posedge i_mclk) begin
		o_lit <= (i_pin_drv[sdd_pkg::PIN_COM0] &&
			i_pin_lvl[sdd_pkg::PIN_COM0] != sdd_pkg::LVL_V0) ||
			(i_pin_lvl[sdd_pkg::PIN_COM1] != sdd_pkg::LVL_V0);
	end
endmodule

// ---- segment_display_driver_config_test.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin error_cnt++; \
	$display("ERROR %s exp %h got %h", n, e, s); end end
module segment_display_driver_config_test;
	logic i_mclk = 0, rstn = 0, wr = 0, rd = 0, tick = 0, slp = 0;
	logic [7:0] addr = 0, wdata = 0, rdata, v, d;
	logic hit, ljoin, lit, flag, xl;
	logic [18:0][1:0] lvl;
	logic [18:0] drv;
	logic [31:0] seed = 32'haae33574;
	logic [7:0] map[8] = '{8'h95, 8'h96, 8'h97, 8'h9c, 8'hac, 8'hae, 8'hb1, 8'hed};
	logic [1:0] shx[3] = '{2'h0, 2'h2, 2'h3};
	int error_cnt = 0, checked = 0, tc = 0;
	////////////////////////////////////////////////////////////////////////
	sdd_top i_sdd_top (.i_mclk(i_mclk), .i_resetn(rstn), .i_sfr_addr(addr),
		.i_sfr_wdata(wdata), .i_sfr_wr(wr), .i_sfr_rd(rd), .o_sfr_rdata(rdata),
		.o_sfr_hit(hit), .i_tick_32k(tick), .i_sleep_power_mode(slp),
		.o_pin_lvl(lvl), .o_pin_drv(drv), .o_ladder_join(ljoin),
		.o_ext_ladder_en(xl), .o_update_finished_flag(flag));
	sdd_panel i_sdd_panel (.i_mclk(i_mclk), .i_pin_lvl(lvl), .i_pin_drv(drv),
		.o_lit(lit));
	// clock, and a fast tick so frames stay short in simulation
	initial forever #12.5 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		tc <= (tc == 3) ? 0 : tc + 1;
		tick <= (tc == 3);
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// bits that a register really keeps
	function automatic logic [7:0] msk(input logic [7:0] a);
		// data locations are one nibble wide
		return (a == 8'h9c) ? 8'h40 : (a == 8'hb1) ? 8'h41 :
			(a == 8'hae) ? 8'h0f : 8'hff;
	endfunction
	task wr8(input logic [7:0] a, input logic [7:0] x);
		@(posedge i_mclk);
		addr <= a;
		wdata <= x;
		wr <= 1'b1;
		@(posedge i_mclk);
		wr <= 1'b0;
	endtask
	// read data lands one cycle after the read edge
	task rd8(input logic [7:0] a);
		@(posedge i_mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_mclk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task final_report();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// bounded wait for a new frame to be taken up
	task wait_flag();
		int n;
		for (n = 0; n < 600 && flag !== 1'b1; n++) @(posedge i_mclk);
		if (n == 600) begin
			error_cnt++;
			final_report();
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge i_mclk);
		rstn <= 1'b1;
		foreach (map[i]) begin
			rd8(map[i]);
			`CHK("reset", 8'h00, v)
			`CHK("hit", 1'b1, hit)
		end
		rd8(8'h90);
		`CHK("unmapped", 1'b0, hit)
		for (int i = 0; i < 10; i++) begin
			d = xs();
			wr8(map[1 + i % 3 * 2], d);
			rd8(map[1 + i % 3 * 2]);
			`CHK("readback", d & msk(map[1 + i % 3 * 2]), v)
		end
		wr8(8'h95, 8'h05);
		wr8(8'h9c, 8'hff);
		rd8(8'h95);
		`CHK("cfg", 8'h05, v)
		`CHK("join", 1'b0, ljoin)
		`CHK("ext", 1'b1, xl)
		$display("test registers done");
		for (int k = 0; k < 18; k++) begin
			wr8(8'hac, k[7:0]);
			wr8(8'hae, 8'h0a ^ k[7:0]);
			rd8(8'hae);
			`CHK("data", (k < 17) ? 8'h0a ^ k[3:0] : 8'h00, v)
		end
		// location 3 holds a non-zero nibble before the clear
		wr8(8'h95, 8'h40);
		wr8(8'hac, 8'h03);
		rd8(8'hae);
		`CHK("clear", 8'h00, v)
		wr8(8'hae, 8'h0f);
		rd8(8'hae);
		`CHK("held", 8'h00, v)
		$display("test memory done");
		// zero frame divider so a frame fits inside the bounded waits
		wr8(8'h96, 8'h00);
		wr8(8'h97, 8'hff);
		wr8(8'hed, 8'h00);
		wr8(8'hb1, 8'h00);
		wr8(8'h95, 8'h83);
		wait_flag();
		repeat (3) @(posedge i_mclk);
		`CHK("lit", 1'b1, lit)
		`CHK("segen", 8'hff, drv[7:0])
		foreach (shx[m]) begin
			wr8(8'h95, 8'h81 + m[7:0]);
			repeat (3) @(posedge i_mclk);
			`CHK("shared", shx[m], drv[16:15])
		end
		slp <= 1'b1;
		wr8(8'h95, 8'h93);
		repeat (4) @(posedge i_mclk);
		`CHK("sleep off", 1'b0, lit)
		wr8(8'h95, 8'h83);
		repeat (80) @(posedge i_mclk);
		`CHK("sleep run", 1'b1, lit)
		// second write lands with hold set, so no frame can set the flag
		wr8(8'hb1, 8'h01);
		wr8(8'hb1, 8'h01);
		repeat (300) @(posedge i_mclk);
		`CHK("hold", 1'b0, flag)
		wr8(8'hb1, 8'h00);
		wait_flag();
		// slow drive clock: no frame can end within the next 600 cycles
		wr8(8'h95, 8'h8b);
		wr8(8'hb1, 8'h00);
		repeat (600) @(posedge i_mclk);
		`CHK("slow", 1'b0, flag)
		wr8(8'h96, 8'h00);
		wr8(8'h95, 8'ha3);
		repeat (4) @(posedge i_mclk);
		`CHK("blink off", 1'b0, lit)
		wr8(8'h96, 8'h40);
		repeat (4) @(posedge i_mclk);
		`CHK("blink on", 1'b1, lit)
		wr8(8'h95, 8'h03);
		repeat (4) @(posedge i_mclk);
		`CHK("disabled", 1'b0, lit)
		$display("test scan done");
		final_report();
	end
endmodule
